// ---- hw/vector_select.sv ----
// Vector base, fast-interrupt slots and vector address choice, APB slave
`timescale 1ns/100ps

module vector_select #(
    parameter int NVEC = 82,
    parameter int VW   = 7
) (
    // Clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // APB slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic                      pready,
    output logic [31:0]               prdata,
    output logic                      pslverr,
    // Requests and their priority fields, two bits per vector number
    input  wire logic [NVEC-1:0]      irq_req,
    input  wire logic [2*NVEC-1:0]    request_priority_field,
    // Vector towards the core
    output logic [20:0]               vector_address_out,
    output logic [VW-1:0]             vector_number,
    output logic [1:0]                vector_level,
    output logic                      vector_valid,
    output logic                      vector_fast,
    output logic                      vector_fast_slot
);

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    vec_sel_pkg::apb_state_type          state_r;
    vec_sel_pkg::apb_state_type          state_nxt;
    logic                                pready_r;
    logic [31:0]                         prdata_r;
    logic                                pslverr_r;
    logic [vec_sel_pkg::VBASE_W-1:0]     vbase_r;
    logic [vec_sel_pkg::SEL_W-1:0]       sel0_r;
    logic [vec_sel_pkg::SEL_W-1:0]       sel1_r;
    logic [vec_sel_pkg::ALOW_W-1:0]      alow0_r;
    logic [vec_sel_pkg::ALOW_W-1:0]      alow1_r;
    logic [vec_sel_pkg::AHIGH_W-1:0]     ahigh0_r;
    logic [vec_sel_pkg::AHIGH_W-1:0]     ahigh1_r;
    logic [20:0]                         vaddr_r;
    logic [20:0]                         vaddr_nxt;
    logic [VW-1:0]                       vnum_r;
    logic [VW-1:0]                       vnum_nxt;
    logic [1:0]                          vlevel_r;
    logic [1:0]                          vlevel_nxt;
    logic                                vvalid_r;
    logic                                vvalid_nxt;
    logic                                vfast_r;
    logic                                vfast_nxt;
    logic                                vslot_r;
    logic                                vslot_nxt;

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------

    // Transfer phases
    wire setup_ph  = psel && !penable;
    wire access_ok = psel && penable && pready_r;

    // Address decode
    wire hit_vbase  = (paddr == vec_sel_pkg::OFF_VECTOR_TABLE_BASE);
    wire hit_sel0   = (paddr == vec_sel_pkg::OFF_FAST_SLOT0_SELECT);
    wire hit_alow0  = (paddr == vec_sel_pkg::OFF_FAST_SLOT0_ADDR_LOW);
    wire hit_ahigh0 = (paddr == vec_sel_pkg::OFF_FAST_SLOT0_ADDR_HIGH);
    wire hit_sel1   = (paddr == vec_sel_pkg::OFF_FAST_SLOT1_SELECT);
    wire hit_alow1  = (paddr == vec_sel_pkg::OFF_FAST_SLOT1_ADDR_LOW);
    wire hit_ahigh1 = (paddr == vec_sel_pkg::OFF_FAST_SLOT1_ADDR_HIGH);
    wire mapped     = hit_vbase || hit_sel0 || hit_alow0 || hit_ahigh0
                   || hit_sel1 || hit_alow1 || hit_ahigh1;

    // A write lands only at the completing access edge of a mapped word
    wire wr_ok = access_ok && pwrite && mapped;

    // Read mux, narrow registers zero-filled above their field
    wire [31:0] rd_word =
          hit_vbase  ? {19'h00000, vbase_r}  :
          hit_sel0   ? {25'h0000000, sel0_r} :
          hit_alow0  ? {16'h0000, alow0_r}   :
          hit_ahigh0 ? {27'h0000000, ahigh0_r} :
          hit_sel1   ? {25'h0000000, sel1_r} :
          hit_alow1  ? {16'h0000, alow1_r}   :
          hit_ahigh1 ? {27'h0000000, ahigh1_r} :
                       32'h00000000;

    // Phase tracker: pready rises at the setup edge, so the first access cycle completes
    always_comb begin
        case (state_r)
            vec_sel_pkg::ST_IDLE:   state_nxt = setup_ph ? vec_sel_pkg::ST_ACCESS
                                                         : vec_sel_pkg::ST_IDLE;
            vec_sel_pkg::ST_ACCESS: state_nxt = access_ok ? vec_sel_pkg::ST_IDLE
                                                          : vec_sel_pkg::ST_ACCESS;
            default:                state_nxt = vec_sel_pkg::ST_IDLE;
        endcase
    end

    // Bus answer flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r   <= vec_sel_pkg::ST_IDLE;
            pready_r  <= 1'b0;
            prdata_r  <= 32'h00000000;
            pslverr_r <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            pready_r  <= (state_nxt == vec_sel_pkg::ST_ACCESS) && !access_ok;
            prdata_r  <= (setup_ph && !pwrite) ? rd_word : prdata_r;
            pslverr_r <= setup_ph ? !mapped : (pslverr_r && !access_ok);
        end
    end

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------

    // Only the implemented low bits are stored, upper write bits dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vbase_r  <= vec_sel_pkg::RST_VBASE;
            sel0_r   <= vec_sel_pkg::RST_SEL;
            sel1_r   <= vec_sel_pkg::RST_SEL;
            alow0_r  <= vec_sel_pkg::RST_ALOW;
            alow1_r  <= vec_sel_pkg::RST_ALOW;
            ahigh0_r <= vec_sel_pkg::RST_AHIGH;
            ahigh1_r <= vec_sel_pkg::RST_AHIGH;
        end else if (wr_ok) begin
            if (hit_vbase)  vbase_r  <= pwdata[12:0];
            if (hit_sel0)   sel0_r   <= pwdata[6:0];
            if (hit_sel1)   sel1_r   <= pwdata[6:0];
            if (hit_alow0)  alow0_r  <= pwdata[15:0];
            if (hit_alow1)  alow1_r  <= pwdata[15:0];
            if (hit_ahigh0) ahigh0_r <= pwdata[4:0];
            if (hit_ahigh1) ahigh1_r <= pwdata[4:0];
        end
    end

    // ----------------------------------------------------------------
    // Request sorting by level
    // ----------------------------------------------------------------
    logic [NVEC-1:0] lvl_req [3];
    logic [2:0]      lvl_found;
    logic [VW-1:0]   lvl_idx [3];

    // Decode each request's two-bit field; vectors below the first
    // maskable number never take part
    generate
        for (genvar v = 0; v < NVEC; v++) begin : g_vec
            wire [1:0] fld  = request_priority_field[2*v+1:2*v];
            wire       live = (v >= vec_sel_pkg::FIRST_IRQ_VEC) && irq_req[v];
            assign lvl_req[0][v] = live && (fld == vec_sel_pkg::PRIO_LEVEL0);
            assign lvl_req[1][v] = live && (fld == vec_sel_pkg::PRIO_LEVEL1);
            assign lvl_req[2][v] = live && (fld == vec_sel_pkg::PRIO_LEVEL2);
        end
        for (genvar l = 0; l < 3; l++) begin : g_lvl
            lowest_req_pick #(
                .W  (NVEC),
                .IW (VW)
            ) u_pick (
                .req   (lvl_req[l]),
                .found (lvl_found[l]),
                .idx   (lvl_idx[l])
            );
        end
    endgenerate

    // Fast slots match only among level-2 requests
    logic fast_hit0;
    logic fast_hit1;

    fast_slot_match #(
        .NVEC (NVEC),
        .SW   (vec_sel_pkg::SEL_W)
    ) u_fast0 (
        .sel      (sel0_r),
        .lvl2_req (lvl_req[2]),
        .hit      (fast_hit0)
    );

    fast_slot_match #(
        .NVEC (NVEC),
        .SW   (vec_sel_pkg::SEL_W)
    ) u_fast1 (
        .sel      (sel1_r),
        .lvl2_req (lvl_req[2]),
        .hit      (fast_hit1)
    );

    // Full addresses for the two ways of vectoring
    wire [20:0] fast_addr0 = {ahigh0_r, alow0_r};
    wire [20:0] fast_addr1 = {ahigh1_r, alow1_r};
    wire [20:0] tbl_addr2  = {vbase_r, lvl_idx[2], 1'b0};
    wire [20:0] tbl_addr1  = {vbase_r, lvl_idx[1], 1'b0};
    wire [20:0] tbl_addr0  = {vbase_r, lvl_idx[0], 1'b0};

    // ----------------------------------------------------------------
    // Winner choice
    // ----------------------------------------------------------------

    // Fast slot 0, fast slot 1, then table vectors from level 2 down
    always_comb begin
        vaddr_nxt  = vaddr_r;
        vnum_nxt   = vnum_r;
        vlevel_nxt = vlevel_r;
        vvalid_nxt = 1'b0;
        vfast_nxt  = 1'b0;
        vslot_nxt  = 1'b0;
        if (fast_hit0) begin
            vaddr_nxt  = fast_addr0;
            vnum_nxt   = sel0_r;
            vlevel_nxt = vec_sel_pkg::LEVEL_2;
            vvalid_nxt = 1'b1;
            vfast_nxt  = 1'b1;
        end else if (fast_hit1) begin
            vaddr_nxt  = fast_addr1;
            vnum_nxt   = sel1_r;
            vlevel_nxt = vec_sel_pkg::LEVEL_2;
            vvalid_nxt = 1'b1;
            vfast_nxt  = 1'b1;
            vslot_nxt  = 1'b1;
        end else if (lvl_found[2]) begin
            vaddr_nxt  = tbl_addr2;
            vnum_nxt   = lvl_idx[2];
            vlevel_nxt = vec_sel_pkg::LEVEL_2;
            vvalid_nxt = 1'b1;
        end else if (lvl_found[1]) begin
            vaddr_nxt  = tbl_addr1;
            vnum_nxt   = lvl_idx[1];
            vlevel_nxt = vec_sel_pkg::LEVEL_1;
            vvalid_nxt = 1'b1;
        end else if (lvl_found[0]) begin
            vaddr_nxt  = tbl_addr0;
            vnum_nxt   = lvl_idx[0];
            vlevel_nxt = vec_sel_pkg::LEVEL_0;
            vvalid_nxt = 1'b1;
        end
    end

    // Vector output flops, last vector held while nothing is active
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vaddr_r  <= 21'h000000;
            vnum_r   <= '0;
            vlevel_r <= vec_sel_pkg::LEVEL_0;
            vvalid_r <= 1'b0;
            vfast_r  <= 1'b0;
            vslot_r  <= 1'b0;
        end else begin
            vaddr_r  <= vaddr_nxt;
            vnum_r   <= vnum_nxt;
            vlevel_r <= vlevel_nxt;
            vvalid_r <= vvalid_nxt;
            vfast_r  <= vfast_nxt;
            vslot_r  <= vslot_nxt;
        end
    end

    // Port drive
    assign pready             = pready_r;
    assign prdata             = prdata_r;
    assign pslverr            = pslverr_r;
    assign vector_address_out = vaddr_r;
    assign vector_number      = vnum_r;
    assign vector_level       = vlevel_r;
    assign vector_valid       = vvalid_r;
    assign vector_fast        = vfast_r;
    assign vector_fast_slot   = vslot_r;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    wire none_live = !lvl_found[0] && !lvl_found[1] && !lvl_found[2];

    property p_ro_zero;
        setup_ph && !pwrite && (hit_vbase || hit_sel0 || hit_ahigh0)
        ##1 psel && penable |-> prdata_r[31:13] == 19'h00000;
    endproperty
    a_ro_zero: assert property (p_ro_zero) else $error("upper bits not zero");

    property p_base_top;
        vvalid_r && !vfast_r |-> vaddr_r[20:8] == $past(vbase_r);
    endproperty
    a_base_top: assert property (p_base_top) else $error("base bits wrong");

    // The request bit is picked from last cycle's vector with today's number,
    // since the number shown now was chosen from last cycle's requests
    property p_low_bits;
        vvalid_r && !vfast_r |-> vaddr_r[7:0] == {vnum_r, 1'b0}
                                 && |($past(irq_req) & (NVEC'(1) << vnum_r));
    endproperty
    a_low_bits: assert property (p_low_bits) else $error("low vector bits wrong");

    property p_sel_write;
        wr_ok && hit_sel1 |=> sel1_r == $past(pwdata[6:0]);
    endproperty
    a_sel_write: assert property (p_sel_write) else $error("select not stored");

    property p_fast0_addr;
        vfast_r && !vslot_r |-> vaddr_r == $past(fast_addr0);
    endproperty
    a_fast0_addr: assert property (p_fast0_addr) else $error("slot 0 address wrong");

    property p_fast1_addr;
        vfast_r && vslot_r |-> vaddr_r == {$past(ahigh1_r), $past(alow1_r)};
    endproperty
    a_fast1_addr: assert property (p_fast1_addr) else $error("slot 1 address wrong");

    property p_fast_wins;
        fast_hit0 || fast_hit1 |=> vfast_r && vvalid_r
                                   && vlevel_r == vec_sel_pkg::LEVEL_2;
    endproperty
    a_fast_wins: assert property (p_fast_wins) else $error("fast request lost");

    property p_slot_order;
        fast_hit0 && fast_hit1 |=> !vslot_r && vnum_r == $past(sel0_r);
    endproperty
    a_slot_order: assert property (p_slot_order) else $error("slot 1 beat slot 0");

    property p_idle_none;
        none_live |=> !vvalid_r;
    endproperty
    a_idle_none: assert property (p_idle_none) else $error("vector without request");

    c_fast0: cover property (fast_hit0 ##1 vfast_r);
    c_both:  cover property (fast_hit0 && fast_hit1);
    c_fast1: cover property (fast_hit1 && !fast_hit0 ##1 vslot_r);
    c_lvl0:  cover property (vvalid_r && vlevel_r == vec_sel_pkg::LEVEL_0);
    c_bad:   cover property (access_ok && pslverr_r);

endmodule

// ---- hw/vec_sel_pkg.sv ----
// Shared constants for the vector base and fast-interrupt select block
package vec_sel_pkg;

    // ----------------------------------------------------------------
    // Register indices and APB byte offsets (byte offset = index * 4)
    // ----------------------------------------------------------------
    localparam logic [5:0] IDX_VECTOR_TABLE_BASE    = 6'h0A;
    localparam logic [5:0] IDX_FAST_SLOT0_SELECT    = 6'h0B;
    localparam logic [5:0] IDX_FAST_SLOT0_ADDR_LOW  = 6'h0C;
    localparam logic [5:0] IDX_FAST_SLOT0_ADDR_HIGH = 6'h0D;
    localparam logic [5:0] IDX_FAST_SLOT1_SELECT    = 6'h0E;
    localparam logic [5:0] IDX_FAST_SLOT1_ADDR_LOW  = 6'h0F;
    localparam logic [5:0] IDX_FAST_SLOT1_ADDR_HIGH = 6'h10;

    localparam logic [7:0] OFF_VECTOR_TABLE_BASE    = {IDX_VECTOR_TABLE_BASE, 2'b00};
    localparam logic [7:0] OFF_FAST_SLOT0_SELECT    = {IDX_FAST_SLOT0_SELECT, 2'b00};
    localparam logic [7:0] OFF_FAST_SLOT0_ADDR_LOW  = {IDX_FAST_SLOT0_ADDR_LOW, 2'b00};
    localparam logic [7:0] OFF_FAST_SLOT0_ADDR_HIGH = {IDX_FAST_SLOT0_ADDR_HIGH, 2'b00};
    localparam logic [7:0] OFF_FAST_SLOT1_SELECT    = {IDX_FAST_SLOT1_SELECT, 2'b00};
    localparam logic [7:0] OFF_FAST_SLOT1_ADDR_LOW  = {IDX_FAST_SLOT1_ADDR_LOW, 2'b00};
    localparam logic [7:0] OFF_FAST_SLOT1_ADDR_HIGH = {IDX_FAST_SLOT1_ADDR_HIGH, 2'b00};

    // ----------------------------------------------------------------
    // Field widths
    // ----------------------------------------------------------------
    localparam int VBASE_W   = 13;
    localparam int SEL_W     = 7;
    localparam int ALOW_W    = 16;
    localparam int AHIGH_W   = 5;
    localparam int VADDR_W   = 21;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [VBASE_W-1:0] RST_VBASE = 13'h0000;
    localparam logic [SEL_W-1:0]   RST_SEL   = 7'h00;
    localparam logic [ALOW_W-1:0]  RST_ALOW  = 16'h0000;
    localparam logic [AHIGH_W-1:0] RST_AHIGH = 5'h00;

    // ----------------------------------------------------------------
    // Request priority field codes and resulting levels
    // ----------------------------------------------------------------
    localparam logic [1:0] PRIO_DISABLED = 2'h0;
    localparam logic [1:0] PRIO_LEVEL0   = 2'h1;
    localparam logic [1:0] PRIO_LEVEL1   = 2'h2;
    localparam logic [1:0] PRIO_LEVEL2   = 2'h3;
    localparam logic [1:0] LEVEL_0       = 2'h0;
    localparam logic [1:0] LEVEL_1       = 2'h1;
    localparam logic [1:0] LEVEL_2       = 2'h2;

    // First vector number that a maskable request may use
    localparam int FIRST_IRQ_VEC = 2;

    // APB transfer phase
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b01,
        ST_ACCESS = 2'b10
    } apb_state_type;

endpackage

// ---- hw/lowest_req_pick.sv ----
// Picks the lowest-numbered active request of a request vector
`timescale 1ns/100ps
module lowest_req_pick #(
    parameter int W  = 82,
    parameter int IW = 7
) (
    // Requests
    input  wire logic [W-1:0]  req,
    // Result
    output logic               found,
    output logic [IW-1:0]      idx
);

    // Scan from the top down so the lowest index is the last to stick
    always_comb begin
        found = 1'b0;
        idx   = '0;
        for (int i = W - 1; i >= 0; i--) begin
            if (req[i]) begin
                found = 1'b1;
                idx   = IW'(i);
            end
        end
    end

endmodule

// ---- hw/fast_slot_match.sv ----
// Tells whether the request named by a fast slot is live at level 2
`timescale 1ns/100ps
module fast_slot_match #(
    parameter int NVEC = 82,
    parameter int SW   = 7
) (
    // Slot selection and level-2 requests
    input  wire logic [SW-1:0]   sel,
    input  wire logic [NVEC-1:0] lvl2_req,
    // Match
    output logic                 hit
);

    // Numbers beyond the request vector never match
    wire in_range = (int'(sel) < NVEC);

    assign hit = in_range && lvl2_req[sel];

endmodule

// ---- sim/core_vector_sink.sv ----
// Core-side model that takes each vector address offered to it
`timescale 1ns/100ps
module core_vector_sink (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Vector from the controller
    input  wire logic        vector_valid,
    input  wire logic [20:0] vector_address_out,
    // Last vector taken
    output logic      [20:0] taken_addr_r
);
    // Latch every offered vector, as a core jumping to it would
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            taken_addr_r <= 21'h000000;
        end else if (vector_valid) begin
            taken_addr_r <= vector_address_out;
        end
    end
endmodule

// ---- sim/test_irq_vector_base_fast_select.sv ----
// Self-checking bench for the vector base and fast-interrupt select block
`timescale 1ns/100ps
module test_irq_vector_base_fast_select;
    localparam int NV = 82;
    // ----------------------------------------------------------------
    // Signals and reference state
    // ----------------------------------------------------------------
    logic            pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic            vector_valid, vector_fast, vector_fast_slot;
    logic [7:0]      paddr;
    logic [31:0]     pwdata, prdata;
    logic [NV-1:0]   irq_req;
    logic [2*NV-1:0] request_priority_field;
    logic [20:0]     vector_address_out, taken_addr_r;
    logic [6:0]      vector_number;
    logic [1:0]      vector_level;
    int              mismatches, cmp_count;
    int              shadow [7];
    int              mask [7] = '{32'h1FFF, 32'h7F, 32'hFFFF, 32'h1F, 32'h7F, 32'hFFFF, 32'h1F};

    vector_select dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .irq_req(irq_req), .request_priority_field(request_priority_field),
        .vector_address_out(vector_address_out), .vector_number(vector_number),
        .vector_level(vector_level), .vector_valid(vector_valid), .vector_fast(vector_fast),
        .vector_fast_slot(vector_fast_slot));
    core_vector_sink core (.pclk(pclk), .presetn(presetn), .vector_valid(vector_valid),
        .vector_address_out(vector_address_out), .taken_addr_r(taken_addr_r));

    // Clock at 50 MHz
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // ----------------------------------------------------------------
    // Helper tasks
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic summarize();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) mismatches++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input int r, input logic [31:0] d);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, vec_sel_pkg::OFF_VECTOR_TABLE_BASE + 8'(4 * r), d, rd, err);
        shadow[r] = d & mask[r];
    endtask

    task automatic rd_all();
        logic [31:0] rd;
        logic        err;
        for (int r = 0; r < 7; r++) begin
            apb(1'b0, vec_sel_pkg::OFF_VECTOR_TABLE_BASE + 8'(4 * r), 32'h0, rd, err);
            chk("register", shadow[r], rd);
            chk("pslverr", 32'h0, err);
        end
    endtask

    // Reference choice of winner and address, compared at the falling edge two cycles after the inputs change
    task automatic vcheck();
        int          win, lvl, slot, sl;
        logic [20:0] ea;
        win = -1;
        slot = -1;
        lvl = 0;
        for (int s = 0; s < 2; s++) begin
            sl = shadow[1 + 3 * s];
            if (win < 0 && sl >= 2 && sl < NV && irq_req[sl]
                && request_priority_field[2 * sl +: 2] == 2'h3) begin
                win = sl;
                slot = s;
                lvl = 2;
                ea = {shadow[3 + 3 * s][4:0], shadow[2 + 3 * s][15:0]};
            end
        end
        for (int l = 3; l >= 1; l--) begin
            for (int i = 2; i < NV; i++) begin
                if (win < 0 && irq_req[i] && request_priority_field[2 * i +: 2] == 2'(l)) begin
                    win = i;
                    lvl = l - 1;
                    ea = {shadow[0][12:0], 7'(i), 1'b0};
                end
            end
        end
        chk("vector_valid", win >= 0, vector_valid);
        if (win >= 0) begin
            chk("vector_address_out", ea, vector_address_out);
            chk("vector_number", win, vector_number);
            chk("vector_level", lvl, vector_level);
            chk("vector_fast", slot >= 0, vector_fast);
            if (slot >= 0) chk("vector_fast_slot", slot, vector_fast_slot);
            chk("taken_addr_r", ea, taken_addr_r);
        end
    endtask

    task automatic apply(input logic [NV-1:0] rq, input logic [2*NV-1:0] pf);
        @(posedge pclk);
        irq_req <= rq;
        request_priority_field <= pf;
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        vcheck();
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [31:0]     rd;
        logic            err;
        logic [NV-1:0]   rq;
        logic [2*NV-1:0] pf;
        int              rs;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        irq_req = '0;
        request_priority_field = '0;
        presetn = 1'b0;
        mismatches = 0;
        cmp_count = 0;
        rs = $urandom(32'h94deb3a4);
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd_all();
        apb(1'b1, 8'h24, 32'hFFFFFFFF, rd, err);
        chk("pslverr", 32'h1, err);
        apb(1'b0, 8'h44, 32'h0, rd, err);
        chk("pslverr", 32'h1, err);
        chk("prdata", 32'h0, rd);
        for (int it = 0; it < 300; it++) begin
            if (it % 10 == 0) begin
                for (int r = 0; r < 7; r++) wr(r, $urandom);
                rd_all();
            end
            for (int i = 0; i < NV; i++) begin
                rq[i] = ($urandom % 8) == 0;
                pf[2 * i +: 2] = 2'($urandom);
            end
            for (int s = 0; s < 2; s++) begin
                if (shadow[1 + 3 * s] < NV) begin
                    pf[2 * shadow[1 + 3 * s] +: 2] = 2'h3;
                    rq[shadow[1 + 3 * s]] = 1'($urandom);
                end
            end
            apply(rq, pf);
        end
        // Second reset in mid-run: registers clear, slots select nothing live
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        shadow = '{default: 0};
        rd_all();
        apply('1, '1);
        summarize();
    end

    // Watchdog against a hung transfer
    initial begin
        #1000000;
        mismatches++;
        summarize();
    end
endmodule
